// ==== upc_link_pkg.sv ====
// constants, register map and carrier types of the converter packet link
package upc_link_pkg;

  // ************************************
  // packet layout
  // ************************************
  localparam int PKT_LEN = 7;
  localparam int LAST_IDX = PKT_LEN - 1;
  localparam logic [7:0] FILLER = 8'hAA;
  localparam logic [7:0] CODE_STATUS = 8'h01;
  localparam logic [7:0] CODE_TX_CTL = 8'h02;
  localparam logic [7:0] CODE_NEW_ADDR = 8'h03;
  localparam logic [7:0] CODE_FREQ = 8'h04;
  localparam logic [3:0] ADDR_MIN = 4'h1;
  localparam logic [3:0] CLASS_MIN = 4'h1;

  // status and version byte fields of the response
  localparam int FLG_TEMP = 0;
  localparam int FLG_UNLOCK = 1;
  localparam int FLG_CKSUM = 2;
  localparam int FLG_TX_ON = 3;
  localparam int CLASS_LSB = 4;
  localparam int VER_LSB = 4;

  // ************************************
  // timing
  // ************************************
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint RESP_TIME_NS = 40_000_000;
  localparam int RESP_TIMEOUT_CYC = int'(RESP_TIME_NS / CLK_PERIOD_NS);

  // ************************************
  // register map (byte offsets)
  // ************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ARG = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RESP0 = 8'h10;
  localparam logic [7:0] OFS_RESP1 = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam int CTRL_GO = 0;
  localparam int CTRL_ABORT = 1;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // interrupt events
  localparam int EV_W = 4;
  localparam int EV_OK = 0;
  localparam int EV_FLAG = 1;
  localparam int EV_BAD = 2;
  localparam int EV_TMO = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} state_t;

  typedef struct packed {
    logic [15:0] power;
    logic [7:0] temp;
    logic [7:0] stat;
    logic [7:0] ver;
  } resp_t;

endpackage

// ==== upc_link.sv ====
// modem side framer for the converter command and response packets
// Contract
// - command is addr, code, four data, checksum
// - command codes one to four as documented
// - seventh byte is eight-bit sum, checked
// - bytes two-three are power, high first
// - byte four is signed temperature
// - status bits flag temp, lock, checksum
// - status bit three tx, top nibble class
// - byte six top nibble is version
// - frequency is sixteen-bit whole megahertz
// - power class decoded to watts
// - resend command when no answer in time
`timescale 1ns/10ps
`default_nettype none

module upc_link
  import upc_link_pkg::*;
#(
  parameter int RESP_TIMEOUT = RESP_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic irq
);

  localparam int TMR_W = 24;

  // ************************************
  // elaboration check
  // ************************************
  if (RESP_TIMEOUT < 2 || RESP_TIMEOUT >= (1 << TMR_W)) begin : g_bad_timeout
    $error("response timeout out of range");
  end

  // ************************************
  // state
  // ************************************
  state_t state_q;
  logic [3:0] cmd_addr_q;
  logic [7:0] cmd_code_q;
  logic [15:0] cmd_arg_q;
  logic [2:0] tx_idx_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_buf_q [LAST_IDX];
  logic [TMR_W-1:0] tmr_q;
  logic [15:0] tries_q;
  resp_t resp_q;
  logic resp_ok_q;
  logic [EV_W-1:0] irq_stat_q;
  logic [EV_W-1:0] irq_en_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic pready_q;
  logic [7:0] tx_data_q;
  logic tx_valid_q;
  logic irq_q;

  // ************************************
  // bus decode
  // ************************************
  wire bus_setup = psel & ~penable;
  wire bus_wr = psel & penable & pwrite & pready_q;
  wire wr_cmd = bus_wr && paddr == OFS_CMD;
  wire wr_arg = bus_wr && paddr == OFS_ARG;
  wire wr_ctrl = bus_wr && paddr == OFS_CTRL;
  wire wr_clr = bus_wr && paddr == OFS_IRQ_CLR;
  wire wr_en = bus_wr && paddr == OFS_IRQ_EN;
  wire go = wr_ctrl & pwdata[CTRL_GO] & (state_q == ST_IDLE);
  wire abort = wr_ctrl & pwdata[CTRL_ABORT];
  wire mapped = paddr == OFS_CMD || paddr == OFS_ARG || paddr == OFS_CTRL
    || paddr == OFS_STAT || paddr == OFS_RESP0 || paddr == OFS_RESP1
    || paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_CLR || paddr == OFS_IRQ_EN;

  // ************************************
  // command packet assembly
  // ************************************
  wire is_freq = cmd_code_q == CODE_FREQ;
  wire is_stat = cmd_code_q == CODE_STATUS;
  wire [7:0] pkt_b0 = {4'h0, cmd_addr_q};
  wire [7:0] pkt_d1 = is_freq ? cmd_arg_q[15:8] : (is_stat ? FILLER : cmd_arg_q[7:0]);
  wire [7:0] pkt_d2 = is_freq ? cmd_arg_q[7:0] : FILLER;
  wire [7:0] pkt_sum = pkt_b0 + cmd_code_q + pkt_d1 + pkt_d2 + FILLER + FILLER;
  wire [7:0] pkt [PKT_LEN];
  assign pkt[0] = pkt_b0;
  assign pkt[1] = cmd_code_q;
  assign pkt[2] = pkt_d1;
  assign pkt[3] = pkt_d2;
  assign pkt[4] = FILLER;
  assign pkt[5] = FILLER;
  assign pkt[6] = pkt_sum;

  wire tx_fire = tx_valid_q & tx_ready;
  wire tx_last = tx_fire && tx_idx_q == 3'(LAST_IDX);
  wire [2:0] tx_next = tx_idx_q + 3'd1;

  // ************************************
  // response check
  // ************************************
  wire rx_take = rx_valid && state_q == ST_WAIT;
  wire rx_done = rx_take && rx_idx_q == 3'(LAST_IDX);
  wire [7:0] rx_sum = rx_buf_q[0] + rx_buf_q[1] + rx_buf_q[2] + rx_buf_q[3]
    + rx_buf_q[4] + rx_buf_q[5];
  wire rx_good = rx_sum == rx_data && rx_buf_q[0] == {cmd_addr_q, 4'h0};
  wire tmo = state_q == ST_WAIT && tmr_q == TMR_W'(RESP_TIMEOUT - 1) && !rx_done;
  resp_t rx_fields;
  // one driver for the whole field bundle
  assign rx_fields = {
    rx_buf_q[1], rx_buf_q[2],
    rx_buf_q[3],
    rx_buf_q[4],
    4'h0, rx_buf_q[5][VER_LSB +: 4]
  };
  wire flag_chg = rx_fields.stat[FLG_TX_ON:0] != resp_q.stat[FLG_TX_ON:0];

  // power class to watts
  wire [3:0] pclass = resp_q.stat[CLASS_LSB +: 4];
  function automatic logic [7:0] class_watts(input logic [3:0] c);
    case (c)
      4'h1: class_watts = 8'd2;
      4'h2: class_watts = 8'd4;
      4'h3: class_watts = 8'd5;
      4'h4: class_watts = 8'd8;
      4'h5: class_watts = 8'd10;
      4'h6: class_watts = 8'd16;
      4'h7: class_watts = 8'd20;
      4'h8: class_watts = 8'd25;
      4'h9: class_watts = 8'd40;
      4'hA: class_watts = 8'd60;
      default: class_watts = 8'd0;
    endcase
  endfunction
  wire [7:0] watts = class_watts(pclass);

  // events: set wins over clear
  wire [EV_W-1:0] ev;
  assign ev[EV_OK] = rx_done & rx_good;
  assign ev[EV_FLAG] = rx_done & rx_good & flag_chg;
  assign ev[EV_BAD] = rx_done & ~rx_good;
  assign ev[EV_TMO] = tmo;
  wire [EV_W-1:0] irq_stat_d = (irq_stat_q & ~(wr_clr ? pwdata[EV_W-1:0] : '0)) | ev;
  wire [EV_W-1:0] irq_en_d = wr_en ? pwdata[EV_W-1:0] : irq_en_q;

  // read mux
  wire [31:0] rd_word =
    paddr == OFS_CMD ? {16'h0000, cmd_code_q, 4'h0, cmd_addr_q} :
    paddr == OFS_ARG ? {16'h0000, cmd_arg_q} :
    paddr == OFS_STAT ? {tries_q, 13'h0000, resp_ok_q, state_q == ST_WAIT, state_q != ST_IDLE} :
    paddr == OFS_RESP0 ? {resp_q.power, resp_q.temp, resp_q.stat} :
    paddr == OFS_RESP1 ? {16'h0000, watts, pclass, resp_q.ver[3:0]} :
    paddr == OFS_IRQ_STAT ? {28'h000_0000, irq_stat_q} :
    paddr == OFS_IRQ_EN ? {28'h000_0000, irq_en_q} : RESET_WORD;

  // ************************************
  // bus slave registers
  // ************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= RESET_WORD;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= 1'b1;
      if (bus_setup) begin
        prdata_q <= pwrite ? RESET_WORD : rd_word;
        pslverr_q <= ~mapped;
      end
    end
  end

  // software writable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_addr_q <= ADDR_MIN;
      cmd_code_q <= CODE_STATUS;
      cmd_arg_q <= 16'h0000;
      irq_en_q <= '0;
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else if (ce) begin
      if (wr_cmd && state_q == ST_IDLE) begin
        cmd_addr_q <= pwdata[3:0];
        cmd_code_q <= pwdata[15:8];
      end
      if (wr_arg && state_q == ST_IDLE) begin
        cmd_arg_q <= pwdata[15:0];
      end
      irq_en_q <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_en_d);
    end
  end

  // ************************************
  // transfer sequencer
  // ************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      tx_idx_q <= 3'd0;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      rx_idx_q <= 3'd0;
      tmr_q <= '0;
      tries_q <= 16'h0000;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_SEND;
            tx_idx_q <= 3'd0;
            tx_data_q <= pkt[0];
            tx_valid_q <= 1'b1;
            tries_q <= 16'h0001;
          end
        end
        ST_SEND: begin
          if (abort) begin
            state_q <= ST_IDLE;
            tx_valid_q <= 1'b0;
          end else if (tx_last) begin
            state_q <= ST_WAIT;
            tx_valid_q <= 1'b0;
            rx_idx_q <= 3'd0;
            tmr_q <= '0;
          end else if (tx_fire) begin
            tx_idx_q <= tx_next;
            tx_data_q <= pkt[tx_next];
          end
        end
        ST_WAIT: begin
          tmr_q <= tmr_q + 1'b1;
          if (rx_take) begin
            rx_idx_q <= rx_idx_q + 3'd1;
          end
          if (abort || (rx_done && rx_good)) begin
            state_q <= ST_IDLE;
          end else if (tmo || rx_done) begin
            // unanswered or bad answer: send the same command again
            state_q <= ST_SEND;
            tx_idx_q <= 3'd0;
            tx_data_q <= pkt[0];
            tx_valid_q <= 1'b1;
            tries_q <= tries_q + 16'h0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          tx_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // response capture, kept only when valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_q <= '0;
      resp_ok_q <= 1'b0;
    end else if (ce) begin
      if (rx_done && rx_good) begin
        resp_q <= rx_fields;
        resp_ok_q <= 1'b1;
      end else if (go) begin
        resp_ok_q <= 1'b0;
      end
    end
  end

  // response byte store
  always_ff @(posedge pclk) begin
    if (ce && rx_take && rx_idx_q < 3'(LAST_IDX)) begin
      rx_buf_q[rx_idx_q] <= rx_data;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_data = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign irq = irq_q;

  // ************************************
  // assertions
  // ************************************
  property p_tx_hold;
    @(posedge pclk) disable iff (!presetn)
    tx_valid && !tx_ready && !abort |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped while stalled");

  property p_first_byte;
    @(posedge pclk) disable iff (!presetn)
    $rose(tx_valid) |-> tx_data == {4'h0, cmd_addr_q} && tx_idx_q == 3'd0;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("first byte not address");

  property p_code_byte;
    @(posedge pclk) disable iff (!presetn)
    tx_valid && tx_idx_q == 3'd1 |-> tx_data == cmd_code_q;
  endproperty
  a_code_byte: assert property (p_code_byte) else $error("second byte not code");

  property p_fill;
    @(posedge pclk) disable iff (!presetn)
    tx_valid && tx_idx_q >= 3'd4 && tx_idx_q <= 3'd5 |-> tx_data == 8'hAA;
  endproperty
  a_fill: assert property (p_fill) else $error("filler byte wrong");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
    ce && tmo && !abort |=> state_q == ST_SEND && tx_valid && irq_stat_q[EV_TMO];
  endproperty
  a_timeout: assert property (p_timeout) else $error("no resend after timeout");

  property p_accept;
    @(posedge pclk) disable iff (!presetn)
    ce && rx_done && rx_good |=> resp_ok_q && state_q == ST_IDLE
      && resp_q.power == $past({rx_buf_q[1], rx_buf_q[2]});
  endproperty
  a_accept: assert property (p_accept) else $error("good response not taken");

  property p_reject;
    @(posedge pclk) disable iff (!presetn)
    ce && rx_done && !rx_good && !abort |=> $stable(resp_q) && state_q == ST_SEND
      && irq_stat_q[EV_BAD];
  endproperty
  a_reject: assert property (p_reject) else $error("bad response accepted");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    irq == |(irq_stat_q & irq_en_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch");

  property p_watts;
    @(posedge pclk) disable iff (!presetn)
    pclass == 4'hA |-> watts == 8'd60;
  endproperty
  a_watts: assert property (p_watts) else $error("power class decode wrong");

endmodule

`default_nettype wire

// ==== upc_model.sv ====
// converter side model that answers command packets over the byte link
`timescale 1ns/10ps
`default_nettype none
module upc_model
  import upc_link_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [3:0] own_addr,
  input wire resp_t fld,
  input wire logic [1:0] fault,
  output logic [55:0] seen
);
  logic [7:0] cmd [7];
  logic [7:0] rsp [7];
  logic [7:0] sum;
  logic tx_req;
  logic used;
  int cnt;
  int rcnt;
  int gap;
  logic [7:0] nxt;
  logic nv;
  // ************************************
  // collect a command, answer after a short gap
  // ************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      seen <= '0;
      tx_req = 1'b0; // carrier off at power-up
      used = 1'b0;
      cnt = 0;
      rcnt = PKT_LEN;
    end else begin
      tx_ready <= ($urandom % 4) != 0; // random stalls
      nv = 1'b0;
      nxt = ~rx_data; // idle line keeps changing
      if (fault == 2'b00) used = 1'b0;
      if (!tx_valid) cnt = 0; // a dropped request restarts framing
      if (tx_valid && tx_ready) begin
        cmd[cnt] = tx_data;
        cnt++;
      end
      if (cnt == PKT_LEN) begin
        cnt = 0;
        seen <= {cmd[0], cmd[1], cmd[2], cmd[3], cmd[4], cmd[5], cmd[6]};
        sum = cmd[0] + cmd[1] + cmd[2] + cmd[3] + cmd[4] + cmd[5];
        if (cmd[0] == {4'h0, own_addr} && cmd[1] >= CODE_STATUS && cmd[1] <= CODE_FREQ) begin
          if (sum == cmd[6] && cmd[1] == CODE_TX_CTL) tx_req = cmd[2][0];
          rsp[0] = {own_addr, 4'h0};
          rsp[1] = fld.power[15:8];
          rsp[2] = fld.power[7:0];
          rsp[3] = fld.temp;
          rsp[4] = {fld.stat[7:4], tx_req & ~fld.stat[1], sum != cmd[6], fld.stat[1:0]};
          rsp[5] = {fld.ver[7:4], 4'hA};
          rsp[6] = rsp[0] + rsp[1] + rsp[2] + rsp[3] + rsp[4] + rsp[5];
          // one spoiled answer when asked for
          if (fault != 2'b00 && !used) begin
            used = 1'b1;
            rsp[6] = rsp[6] + ((fault == 2'b01) ? 8'h01 : 8'h10);
            if (fault == 2'b10) rsp[0] = rsp[0] + 8'h10;
          end
          rcnt = 0;
          gap = 3;
        end
      end else if (rcnt < PKT_LEN) begin
        if (gap > 0) begin
          gap--;
        end else begin
          nxt = rsp[rcnt];
          nv = 1'b1;
          rcnt++;
          gap = 1;
        end
      end
      rx_data <= nxt;
      rx_valid <= nv;
    end
  end
endmodule
`default_nettype wire

// ==== upc_link_tb.sv ====
// self-checking bench of the converter packet link
`timescale 1ns/10ps
`default_nettype none
module upc_link_tb
  import upc_link_pkg::*;
;
  localparam int TMO = 50;
  localparam logic [7:0] WATTS [16] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0A, 8'h10,
    8'h14, 8'h19, 8'h28, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RST_OFS [6] = '{OFS_CMD, OFS_ARG, OFS_STAT, OFS_RESP0,
    OFS_IRQ_STAT, OFS_IRQ_EN};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, tx_valid, tx_ready, rx_valid, irq, err;
  logic [7:0] tx_data, rx_data;
  logic [3:0] own = 4'h5;
  resp_t fld = '0;
  logic [1:0] fault = 2'b00;
  logic [55:0] seen;
  logic tx_exp = 1'b0;
  logic [3:0] prev = 4'h0;
  logic [3:0] cls_pick = 4'h0;
  logic [31:0] rd;
  int bad_count = 0;
  int checks_done = 0;

  always #50 pclk = ~pclk;

  upc_link #(.RESP_TIMEOUT(TMO)) u_upc_link (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .irq(irq));
  upc_model u_upc_model (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .own_addr(own), .fld(fld), .fault(fault), .seen(seen));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      end_of_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll a register until masked bits match
  task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end while ((rd & m) !== v && n < 300);
    if ((rd & m) !== v) begin
      bad_count++;
      end_of_test;
    end
  endtask

  function automatic logic [55:0] exp_cmd(input logic [7:0] c, input logic [3:0] a,
      input logic [15:0] g);
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] s;
    d1 = (c == CODE_FREQ) ? g[15:8] : ((c == CODE_STATUS) ? FILLER : g[7:0]);
    d2 = (c == CODE_FREQ) ? g[7:0] : FILLER;
    s = {4'h0, a} + c + d1 + d2 + FILLER + FILLER;
    return {4'h0, a, c, d1, d2, FILLER, FILLER, s};
  endfunction

  function automatic logic [15:0] arg_for(input logic [7:0] c);
    if (c == CODE_TX_CTL) return 16'($urandom % 2);
    if (c == CODE_NEW_ADDR) return {12'h000, own};
    return 16'($urandom);
  endfunction

  // full command and response round trip with checks
  task automatic txn(input logic [7:0] code, input logic [15:0] arg, input logic [1:0] f);
    logic [7:0] st;
    logic [3:0] ev;
    logic [3:0] cls;
    logic [3:0] ver;
    cls = (cls_pick != 4'h0) ? cls_pick : 4'(($urandom % 15) + 1);
    ver = 4'($urandom);
    fld <= '{16'($urandom), 8'($urandom), {cls, 2'b00, 2'($urandom)}, {ver, 4'h0}};
    fault <= f;
    apb(1'b1, OFS_CMD, {16'h0000, code, 4'h0, own});
    apb(1'b1, OFS_ARG, {16'h0000, arg});
    apb(1'b1, OFS_CTRL, 32'h0000_0001 << CTRL_GO);
    wait_reg(OFS_STAT, 32'h0000_0001, 32'h0000_0000);
    fault <= 2'b00;
    if (code == CODE_TX_CTL) tx_exp = arg[0];
    st = {cls, tx_exp & ~fld.stat[1], 1'b0, fld.stat[1:0]};
    chk("command", exp_cmd(code, own, arg), seen);
    chk("status", {(f != 2'b00) ? 16'h0002 : 16'h0001, 16'h0004}, rd);
    apb(1'b0, OFS_RESP0, 32'h0000_0000);
    chk("resp0", {fld.power, fld.temp, st}, rd);
    apb(1'b0, OFS_RESP1, 32'h0000_0000);
    chk("resp1", {16'h0000, WATTS[cls], cls, ver}, rd);
    ev = {1'b0, f != 2'b00, st[3:0] != prev, 1'b1};
    prev = st[3:0];
    apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
    chk("irq_stat", {28'h000_0000, ev}, rd);
    chk("irq", 1'b1, irq);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("irq masked", 1'b0, irq);
    apb(1'b1, OFS_IRQ_CLR, 32'h0000_000F);
    apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
    chk("irq cleared", 32'h0000_0000, rd);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_000F);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end

  // ************************************
  // main sequence
  // ************************************
  initial begin
    int i;
    logic [7:0] c;
    void'($urandom(32'hc4ed_0b84));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, RST_OFS[i], 32'h0000_0000);
      chk("reset value", (i == 0) ? 32'h0000_0101 : 32'h0000_0000, rd);
    end
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("unmapped read", {31'h0000_0000, 1'b1}, {rd[30:0], err});
    apb(1'b1, 8'h24, 32'h0000_0001);
    chk("unmapped write", 1'b1, err);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_000F);
    for (i = 1; i <= 4; i++) txn(8'(i), arg_for(8'(i)), 2'b00);
    cls_pick = 4'hA; // largest decoded class
    txn(CODE_FREQ, 16'hFFFF, 2'b00);
    cls_pick = 4'h0;
    txn(CODE_FREQ, 16'h0000, 2'b01);
    txn(CODE_TX_CTL, 16'h0001, 2'b10);
    for (i = 0; i < 12; i++) begin
      c = 8'(($urandom % 4) + 1);
      txn(c, arg_for(c), 2'($urandom % 3));
    end
    // foreign address: ignored, times out, resent, then aborted
    apb(1'b1, OFS_CMD, {16'h0000, CODE_STATUS, 4'h0, own + 4'h1});
    apb(1'b1, OFS_CTRL, 32'h0000_0001 << CTRL_GO);
    wait_reg(OFS_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
    wait_reg(OFS_STAT, 32'h0000_0002, 32'h0000_0002);
    chk("resend count", 1'b1, rd[31:16] >= 16'h0002);
    apb(1'b1, OFS_CMD, 32'h0000_0101);
    apb(1'b0, OFS_CMD, 32'h0000_0000);
    chk("cmd held", {16'h0000, CODE_STATUS, 4'h0, own + 4'h1}, rd);
    apb(1'b1, OFS_CTRL, 32'h0000_0001 << CTRL_ABORT);
    wait_reg(OFS_STAT, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, OFS_IRQ_CLR, 32'h0000_000F);
    txn(CODE_STATUS, 16'h0000, 2'b00);
    end_of_test;
  end
endmodule
`default_nettype wire
